// ### rtl/led_sink_pkg.sv
`default_nettype none
package led_sink_pkg;

  localparam int CHANNELS = 16;
  localparam int GROUPS   = 9;

  // Clock rate and timing figures
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int GROUP_DELAY_PS    = 1000;
  localparam int PRECHG_DELAY_PS   = 10000;
  // Longest time: rounds down, never below one cycle
  localparam int GROUP_DELAY_CYC   = (GROUP_DELAY_PS / CLK_PERIOD_PS) < 1 ? 1 : (GROUP_DELAY_PS / CLK_PERIOD_PS);
  // Least time: rounds up
  localparam int PRECHG_DELAY_CYC  = (PRECHG_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STAGE_DEPTH       = GROUPS * GROUP_DELAY_CYC;

  // Pin samples travel together through the synchroniser
  typedef struct packed {
    logic blank;
    logic latch_transfer;
    logic serial_in;
    logic serial_clk;
  } pin_sample_t;

  // Blank comes out of reset high so the sinks start off
  localparam logic [3:0] PIN_RESET       = 4'h8;
  localparam logic [15:0] SINK_RESET     = 16'h0000;
  localparam logic [3:0] PRECHG_CNT_ZERO = 4'h0;

endpackage
`default_nettype wire

// ### rtl/led_sink_onoff_shift_latch.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Each serial clock rising edge loads the serial input bit into bit 0 of the 16-bit shift register.
// - The cascade output changes only on serial clock rising edges.
// - While latch transfer is high the output latch follows the shift register, shifts included.
// - While latch transfer is low the output latch holds its pattern whatever the shift register does.
// - With blank low a channel sinks when its latched bit is 1 and is off when it is 0.
// - While blank is high all channels are off, and with latch transfer low the latch keeps its contents.
// - Shift register and latch have no reset and no defined value after power-up.
// - Channels switch in nine groups of one or two, one clock (five nanoseconds) apart.
// - Groups are channel 0, then 1+15, 2+14, 3+13, 4+12, 5+11, 6+10, 7+9, and 8 last.
// - The group stagger applies to turn-on and turn-off on every blank edge.
// - The group stagger also applies when latched data change while blank is low.
// - Shortly after a drive period ends the pre-charge pull-up is switched on.
// - Each serial clock rising edge moves every shift register bit one place toward the MSB.
// - The cascade output is the shift register MSB, sixteen serial clocks behind the input.
module led_sink_onoff_shift_latch #(
  parameter int CHANNELS = led_sink_pkg::CHANNELS
) (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                serial_clk,
  input  wire logic                serial_in,
  input  wire logic                latch_transfer,
  input  wire logic                blank,
  output var  logic [CHANNELS-1:0] sink_channel,
  output var  logic                cascade_out,
  output var  logic                precharge
);
  import led_sink_pkg::*;

  // Group index of a channel: 0 alone, mirrored pairs, 8 last
  function automatic int group_of(input int ch);
    if (ch == 0) begin
      return 0;
    end
    else if (ch <= CHANNELS / 2) begin
      return ch;
    end
    else begin
      return CHANNELS - ch;
    end
  endfunction

  pin_sample_t             pin_s1;
  pin_sample_t             pin_s2;
  pin_sample_t             pin_s3;
  pin_sample_t             pin_f;
  pin_sample_t             pin_prev;
  logic [CHANNELS-1:0]     shift_reg;
  logic [CHANNELS-1:0]     latch_reg;
  // Stage k holds the gated pattern as it stood k+1 clocks ago
  logic [CHANNELS-1:0]     stage [0:STAGE_DEPTH-1];
  logic [3:0]              prechg_cnt;

  // All four pins share one synchroniser and one filter
  wire pin_sample_t        raw_pins = '{blank: blank, latch_transfer: latch_transfer,
                                        serial_in: serial_in, serial_clk: serial_clk};
  // A pin change counts once the second and third stages agree
  wire logic [3:0]         agree = ~(pin_s2 ^ pin_s3);
  wire logic [3:0]         next_pin_f = (agree & pin_s2) | (~agree & pin_f);
  wire logic               sclk_rise = pin_f.serial_clk & ~pin_prev.serial_clk;
  wire logic               lat_f = pin_f.latch_transfer;
  wire logic               blank_f = pin_f.blank;
  wire logic [CHANNELS-1:0] next_shift = {shift_reg[CHANNELS-2:0], pin_f.serial_in};
  // Register reloads itself between serial clock rises, so no enable is needed
  wire logic [CHANNELS-1:0] shift_now = sclk_rise ? next_shift : shift_reg;
  // Transparent latch tracks the register as it stands after this edge, never a phantom shift
  wire logic [CHANNELS-1:0] next_latch = lat_f ? shift_now : latch_reg;
  wire logic [CHANNELS-1:0] target = blank_f ? '0 : latch_reg;
  wire logic [CHANNELS-1:0] next_sink;
  // Counter saturates at the settle time and clears as soon as blank falls
  wire logic [3:0]         next_prechg_cnt = !blank_f ? PRECHG_CNT_ZERO :
                                             (prechg_cnt == 4'(PRECHG_DELAY_CYC)) ? prechg_cnt :
                                             4'(prechg_cnt + 4'h1);

  assign cascade_out = shift_reg[CHANNELS-1];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1   <= PIN_RESET;
      pin_s2   <= PIN_RESET;
      pin_s3   <= PIN_RESET;
      pin_f    <= PIN_RESET;
      pin_prev <= PIN_RESET;
    end
    else begin
      pin_s1   <= raw_pins;
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_f    <= next_pin_f;
      pin_prev <= pin_f;
    end
  end

  // No reset on the pattern storage: it powers up random
  always_ff @(posedge mclk) begin
    shift_reg <= shift_now;
    latch_reg <= next_latch;
  end

  // Each stage is one group delay; a change of blank or latch ripples group by group
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < STAGE_DEPTH; i++) begin
        stage[i] <= SINK_RESET;
      end
    end
    else begin
      stage[0] <= target;
      for (int i = 1; i < STAGE_DEPTH; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  // Each channel taps the stage that matches its group's place in the stagger
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_tap
    assign next_sink[ch] = stage[group_of(ch) * GROUP_DELAY_CYC][ch];
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sink_channel <= SINK_RESET;
    end
    else begin
      sink_channel <= next_sink;
    end
  end

  // Pull-up comes on a short settle time after blank rises and drops as soon as blank falls
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prechg_cnt <= PRECHG_CNT_ZERO;
      precharge  <= 1'b0;
    end
    else begin
      prechg_cnt <= next_prechg_cnt;
      precharge  <= blank_f && (prechg_cnt == 4'(PRECHG_DELAY_CYC));
    end
  end

  // Pattern storage has no reset, so its checks, apart from the two bit-0 serial input checks, use case equality to stay quiet on power-up unknowns
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Shift register and latch
  chk_shift_lsb_load: assert property (sclk_rise |=> shift_reg[0] == $past(pin_f.serial_in))
    else $error("shift register LSB did not take serial input");
  chk_shift_toward_msb: assert property (sclk_rise |=> shift_reg[15:1] === $past(shift_reg[14:0]))
    else $error("shift register did not move toward MSB");
  chk_cascade_only_rise: assert property (!sclk_rise |=> cascade_out === $past(cascade_out))
    else $error("cascade output changed without serial clock rise");
  chk_cascade_msb_path: assert property (sclk_rise |=> cascade_out === $past(shift_reg[14]))
    else $error("cascade output is not the shifted MSB");
  chk_latch_follows_shift: assert property (lat_f && sclk_rise |=> latch_reg[0] == $past(pin_f.serial_in))
    else $error("latch did not follow shift while transparent");
  chk_latch_holds: assert property (!lat_f |=> latch_reg === $past(latch_reg))
    else $error("latch changed while transfer low");
  chk_latch_tracks: assert property (lat_f |=> latch_reg === shift_reg)
    else $error("transparent latch differs from shift register");
  chk_shift_idle_hold: assert property (!sclk_rise |=> shift_reg === $past(shift_reg))
    else $error("shift register moved without serial clock rise");
  chk_blank_keeps_latch: assert property (blank_f && !lat_f |=> latch_reg === $past(latch_reg))
    else $error("latch lost its contents under blank");
  chk_sink_settled: assert property ($stable(target) [*8] ##1 $stable(target) |=> sink_channel === $past(target))
    else $error("settled sinks differ from gated latch");

  // Group stagger
  chk_blank_all_off: assert property (blank_f [*8] ##1 blank_f |=> ##1 sink_channel == '0)
    else $error("channels not off under blank");
  chk_group_first: assert property (sink_channel[0] == $past(target[0], 2))
    else $error("channel 0 not following its group timing");
  chk_group_pair: assert property (sink_channel[15] == $past(target[15], 3) && sink_channel[1] == $past(target[1], 3))
    else $error("channels 1 and 15 not switched together");
  chk_group_last: assert property (sink_channel[8] == $past(target[8], 10))
    else $error("last group not delayed by eight group steps");
  chk_group_two: assert property (sink_channel[2] == $past(target[2], 4) && sink_channel[14] == $past(target[14], 4))
    else $error("channels 2 and 14 not switched together");
  chk_group_three: assert property (sink_channel[3] == $past(target[3], 5) && sink_channel[13] == $past(target[13], 5))
    else $error("channels 3 and 13 not switched together");
  chk_group_four: assert property (sink_channel[4] == $past(target[4], 6) && sink_channel[12] == $past(target[12], 6))
    else $error("channels 4 and 12 not switched together");
  chk_group_five: assert property (sink_channel[5] == $past(target[5], 7) && sink_channel[11] == $past(target[11], 7))
    else $error("channels 5 and 11 not switched together");
  chk_group_six: assert property (sink_channel[6] == $past(target[6], 8) && sink_channel[10] == $past(target[10], 8))
    else $error("channels 6 and 10 not switched together");
  chk_group_seven: assert property (sink_channel[7] == $past(target[7], 9) && sink_channel[9] == $past(target[9], 9))
    else $error("channels 7 and 9 not switched together");

  // Both edges of blank ripple through the groups
  chk_sink_blank_first: assert property ($rose(blank_f) |=> ##1 !sink_channel[0])
    else $error("channel 0 not off two clocks after blank");
  chk_sink_blank_last: assert property ($rose(blank_f) |-> ##10 !sink_channel[8])
    else $error("channel 8 not off ten clocks after blank");
  chk_sink_unblank_first: assert property ($fell(blank_f) |=> ##1 sink_channel[0] === $past(latch_reg[0], 2))
    else $error("channel 0 not restored two clocks after unblank");
  chk_sink_unblank_last: assert property ($fell(blank_f) |-> ##10 sink_channel[8] === $past(latch_reg[8], 10))
    else $error("channel 8 not restored ten clocks after unblank");

  // Pre-charge
  chk_precharge_delay: assert property ($rose(blank_f) ##0 blank_f [*4] |-> precharge)
    else $error("pre-charge not on after blank settle time");
  chk_precharge_blank: assert property (precharge |-> $past(blank_f))
    else $error("pre-charge on while driving");
  chk_precharge_low: assert property (!blank_f |=> !precharge)
    else $error("pre-charge not off after blank fell");
  chk_precharge_hold: assert property (precharge && blank_f |=> precharge)
    else $error("pre-charge dropped while blank high");

  // Main scenarios the bench should reach
  cov_transparent_shift: cover property (lat_f && sclk_rise);
  cov_blank_rise: cover property ($rose(blank_f));
  cov_blank_fall_on: cover property ($fell(blank_f) && latch_reg != '0);
  cov_precharge_on: cover property ($rose(precharge));
  cov_hold_shift: cover property (!lat_f && sclk_rise);

endmodule
`default_nettype wire

// ### verification/led_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module led_ctrl_model (
  output var logic serial_clk,
  output var logic serial_in,
  output var logic latch_transfer,
  output var logic blank
);
  initial begin
    serial_clk     = 1'b0;
    serial_in      = 1'b0;
    latch_transfer = 1'b0;
    blank          = 1'b1;
  end
  // Link clock idles low between frames; 32 ns set-up and hold around each rise
  task automatic send(input logic [15:0] w, input logic lat);
    latch_transfer = lat;
    for (int i = 15; i >= 0; i--) begin
      serial_in = w[i];
      #32 serial_clk = 1'b1;
      #32 serial_clk = 1'b0;
    end
    serial_in = ~serial_in;
    #32 latch_transfer = 1'b0;
  endtask
  task automatic set_blank(input logic b);
    blank = b;
  endtask
endmodule
`default_nettype wire

// ### verification/test_led_sink_onoff_shift_latch.sv
`timescale 1ns/1ps
`default_nettype none
module test_led_sink_onoff_shift_latch;
  import led_sink_pkg::*;
  logic        mclk, reset_n, serial_clk, serial_in, latch_transfer, blank, cascade_out, precharge;
  logic [15:0] sink_channel, word_a, word_b;
  int          errors = 0;
  int          compares = 0;
  int          seed = 32'h1b69;
  int          n;
  led_ctrl_model ctrl (.serial_clk(serial_clk), .serial_in(serial_in),
    .latch_transfer(latch_transfer), .blank(blank));
  led_sink_onoff_shift_latch dut (.mclk(mclk), .reset_n(reset_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .latch_transfer(latch_transfer), .blank(blank),
    .sink_channel(sink_channel), .cascade_out(cascade_out), .precharge(precharge));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [15:0] gated(input logic [15:0] w, input logic b);
    return b ? 16'h0000 : w;
  endfunction
  // Filter plus shift plus nine group steps stays well inside this
  task automatic settle;
    repeat (24) @(posedge mclk);
    #1;
  endtask
  initial begin
    reset_n = 1'b0;
    repeat (10) @(posedge mclk);
    #1 check("reset sinks", sink_channel, SINK_RESET);
    check("reset prechg", {15'h0000, precharge}, 16'h0000);
    reset_n = 1'b1;
    settle;
    check("blank at power up", sink_channel, 16'h0000);
    ctrl.send(16'hFFFF, 1'b1);
    settle;
    check("blank over latch", sink_channel, gated(16'hFFFF, 1'b1));
    ctrl.set_blank(1'b0);
    for (n = 0; n < 200 && sink_channel[0] !== 1'b1; n++) @(posedge mclk) #1;
    check("first group", {15'h0000, sink_channel[0]}, 16'h0001);
    check("last group", {15'h0000, sink_channel[8]}, 16'h0000);
    settle;
    check("all on", sink_channel, 16'hFFFF);
    $display("test stagger done");
    for (n = 0; n < 6; n++) begin
      word_a = (n == 0) ? 16'h0001 : (n == 1) ? 16'h8000 : 16'($random(seed));
      ctrl.send(word_a, 1'b1);
      settle;
      check("transparent", sink_channel, gated(word_a, 1'b0));
    end
    $display("test transparent done");
    word_b = 16'($random(seed));
    ctrl.send(word_b, 1'b0);
    settle;
    check("held", sink_channel, word_a);
    check("cascade", {15'h0000, cascade_out}, {15'h0000, word_b[15]});
    $display("test hold done");
    ctrl.set_blank(1'b1);
    settle;
    check("blanked", sink_channel, 16'h0000);
    check("prechg on", {15'h0000, precharge}, 16'h0001);
    ctrl.set_blank(1'b0);
    settle;
    check("restored", sink_channel, word_a);
    check("prechg off", {15'h0000, precharge}, 16'h0000);
    $display("test blank done");
    give_verdict;
  end
endmodule
`default_nettype wire
